//--- testbench.sv
// Self-checking bench for the ULPI pin-control block
`timescale 1ns/1ps
module testbench;
    import upc_pkg::*;
    logic       sys_clk, rst_b, chip_select_powerdown_n, io_supply_present;
    logic       suspend_req, ext_fault_input_enable, fault_polarity_invert;
    logic       external_supply_drive, fault_pin, vbus_valid, link_stp;
    logic       rx_valid, rx_is_usb, rx_ready, tx_ready, tx_valid, tx_last;
    logic       ulpi_clk_out, ulpi_clk_oe, ulpi_dir, ulpi_dir_oe, ulpi_nxt;
    logic       ulpi_nxt_oe, ulpi_data_oe, vbus_switch_enable_n_out;
    logic       vbus_switch_enable_n_oe, powered_down, psw_pin, pc;
    logic [7:0] link_data_in, link_drive, rx_byte, tx_byte, ulpi_data_out;
    logic [7:0] cmd;
    logic [1:0] vbus_state;
    logic [8:0] exp_q[$];
    logic [7:0] tx_q[$];
    int         fail_count, total_checks, seed, i, n;
    bit         ok, seen_last;

    ////////////////////////////////////////////////////////////////////
    // Data pins: device, then weak pull-down while DIR is high, else link
    assign link_data_in = ulpi_data_oe ? ulpi_data_out :
                          (ulpi_dir ? 8'h00 : link_drive);
    // Open-drain switch pin with its external pull-up
    assign psw_pin = vbus_switch_enable_n_oe ? vbus_switch_enable_n_out : 1'b1;

    upc_top dut_u (.sys_clk, .rst_b, .chip_select_powerdown_n,
        .io_supply_present, .suspend_req, .ext_fault_input_enable,
        .fault_polarity_invert, .external_supply_drive, .fault_pin,
        .vbus_valid, .link_stp, .link_data_in, .rx_valid, .rx_byte,
        .rx_is_usb, .rx_ready, .tx_ready, .tx_valid, .tx_byte, .tx_last,
        .ulpi_clk_out, .ulpi_clk_oe, .ulpi_dir, .ulpi_dir_oe, .ulpi_nxt,
        .ulpi_nxt_oe, .ulpi_data_out, .ulpi_data_oe,
        .vbus_switch_enable_n_out, .vbus_switch_enable_n_oe,
        .powered_down, .vbus_state);
    upc_link_model link_u (.ulpi_clk_out, .ulpi_dir, .ulpi_nxt, .link_stp,
        .link_drive);

    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    // Bounded wait; running out shows as a DIR mismatch
    task automatic wait_dir(input logic v, input int lim);
        int j;
        for (j = 0; j < lim && ulpi_dir !== v; j++) step(1);
        chk("dir", ulpi_dir, v);
    endtask

    ////////////////////////////////////////////////////////////////////
    // Note each byte handed over, then offer a fresh random one
    always @(posedge sys_clk) begin
        if (rx_ready === 1'b1) begin
            exp_q.push_back({rx_is_usb, rx_byte});
            #1;
            rx_byte   = 8'($random(seed));
            rx_is_usb = ~rx_is_usb;
        end
    end
    // Pins stand a whole tick, so look one edge later to be safe
    always @(posedge sys_clk) begin : cmp_send
        logic [8:0] e;
        if (rx_ready === 1'b1) begin
            @(posedge sys_clk);
            #1;
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                chk("nxt_out", ulpi_nxt, e[8]);
                chk("data_out", ulpi_data_out, e[7:0]);
            end
        end
    end
    // Bytes taken from the link
    always @(posedge sys_clk) begin
        if (tx_valid === 1'b1 && tx_q.size() == 0)
            chk("tx_extra", 1'b1, 1'b0);
        else if (tx_valid === 1'b1)
            chk("tx_byte", tx_byte, tx_q.pop_front());
        if (tx_last === 1'b1)
            seen_last = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        seed = 74135;
        {fail_count, total_checks, seen_last} = '0;
        {rst_b, chip_select_powerdown_n, suspend_req, fault_pin} = 4'h0;
        {ext_fault_input_enable, fault_polarity_invert} = 2'b00;
        {external_supply_drive, rx_valid, rx_byte} = '0;
        {io_supply_present, vbus_valid, rx_is_usb, tx_ready} = 4'hF;
        // Look after a clock edge so reset has surely been applied
        step(2);
        chk("dir_rst", ulpi_dir, 1'b1);
        chk("nxt_rst", ulpi_nxt, 1'b0);
        chk("psw_rst", psw_pin, 1'b1);
        rst_b = 1'b1;
        step(40);
        chk("dir_pwrup", ulpi_dir, 1'b1);
        wait_dir(1'b0, 400);
        $display("reset test done");
        // Interface clock rate: 500 system cycles hold 120 ticks
        n = 0;
        pc = ulpi_clk_out;
        for (i = 0; i < 500; i++) begin
            step(1);
            if (ulpi_clk_out && !pc) n++;
            pc = ulpi_clk_out;
        end
        chk("clk_rate", 32'(n inside {[119:121]}), 1);
        $display("clock test done");
        // Switch drive, every fault enable and polarity case
        external_supply_drive = 1'b1; // host role, ID seen low
        step(6);
        chk("psw_on", psw_pin, 1'b0);
        for (i = 0; i < 8; i++) begin
            {ext_fault_input_enable, fault_polarity_invert, fault_pin} = 3'(i);
            step(6);
            chk("vbus_st", vbus_state,
                (i >= 4 && (i[1] ^ i[0])) ? 2'b00 : 2'b11);
        end
        // Comparator low reads as a fault; the link drops the drive bit
        vbus_valid = 1'b0;
        step(6);
        chk("vbus_low", vbus_state, 2'b00);
        if (vbus_state !== 2'b11) external_supply_drive = 1'b0;
        step(6);
        chk("psw_off", psw_pin, 1'b1);
        vbus_valid = 1'b1;
        ext_fault_input_enable = 1'b0;
        $display("vbus test done");
        // Link transmit: command, NXT request, STP close
        cmd = 8'($random(seed)) | 8'h01;
        tx_q.push_back(cmd);
        seen_last = 1'b0;
        link_u.transmit(cmd, ok);
        chk("nxt_req", ok, 1'b1);
        for (i = 0; i < 100 && !seen_last; i++) step(1);
        chk("tx_last", seen_last, 1'b1);
        chk("tx_left", tx_q.size(), 0);
        step(10);
        chk("nxt_idle", ulpi_nxt, 1'b0);
        $display("transmit test done");
        // Send stream to the link, mixed data and status bytes
        rx_valid = 1'b1;
        wait_dir(1'b1, 50);
        step(40);
        rx_valid = 1'b0;
        wait_dir(1'b0, 40);
        $display("send test done");
        // Abort by STP while the device is still sending
        rx_valid = 1'b1;
        wait_dir(1'b1, 50);
        step(12);
        fork
            link_u.abort();
            wait_dir(1'b0, 20);
        join
        rx_valid = 1'b0;
        wait_dir(1'b0, 40);
        $display("abort test done");
        // Chip-select power-down, then missing I/O supply
        chip_select_powerdown_n = 1'b1;
        step(6);
        chk("pd_cs", powered_down, 1'b1);
        chk("oe_cs", {ulpi_clk_oe, ulpi_dir_oe, ulpi_nxt_oe, ulpi_data_oe},
            4'h0);
        chip_select_powerdown_n = 1'b0;
        wait_dir(1'b0, 400);
        io_supply_present = 1'b0;
        step(6);
        chk("pd_io", powered_down, 1'b1);
        io_supply_present = 1'b1;
        wait_dir(1'b0, 400);
        $display("power test done");
        // Suspend blocks the bus, then a reset in mid-run
        suspend_req = 1'b1;
        step(20);
        chk("dir_susp", ulpi_dir, 1'b1);
        suspend_req = 1'b0;
        wait_dir(1'b0, 400);
        rst_b = 1'b0;
        #1;
        chk("dir_rst2", ulpi_dir, 1'b1);
        chk("nxt_rst2", ulpi_nxt, 1'b0);
        step(2);
        rst_b = 1'b1;
        wait_dir(1'b0, 400);
        $display("suspend and reset test done");
        end_sim();
    end
endmodule // testbench

//--- upc_clk_gen.sv
// Interface clock generator from the system clock
`timescale 1ns/1ps
module upc_clk_gen
    import upc_pkg::*;
(
    input  wire logic sys_clk,
    input  wire logic rst_b,
    input  wire logic run,
    upc_tick_if.src   tk
);
    logic [7:0] acc;
    logic [7:0] next_acc;
    logic       clk_lvl;
    logic       next_clk_lvl;
    logic       tick;
    logic       next_tick;

    // Phase accumulator; jitter of one sys_clk is accepted
    always_comb begin
        next_acc     = acc;
        next_clk_lvl = clk_lvl;
        next_tick    = 1'b0;
        if (!run) begin
            next_acc     = ACC_RESET;
            next_clk_lvl = 1'b0;
        end else if ({1'b0, acc} + {1'b0, ACC_INC} * 9'd2 >= {1'b0, ACC_MOD})
        begin
            next_acc     = 8'(acc + ACC_INC * 8'd2 - ACC_MOD);
            next_clk_lvl = ~clk_lvl;
            next_tick    = ~clk_lvl; // Rising edge
        end else begin
            next_acc = 8'(acc + ACC_INC * 8'd2);
        end
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            acc     <= ACC_RESET;
            clk_lvl <= 1'b0;
            tick    <= 1'b0;
        end else begin
            acc     <= next_acc;
            clk_lvl <= next_clk_lvl;
            tick    <= next_tick;
        end
    end

    assign tk.tick    = tick;
    assign tk.clk_out = clk_lvl;

    chk_tick_rising: assert property (@(posedge sys_clk) disable iff (!rst_b)
        tick |-> clk_lvl)
        else $error("tick without clock high");
endmodule // upc_clk_gen

//--- upc_link_model.sv
// Behavioural link controller facing the ULPI pins of the block
`timescale 1ns/1ps
module upc_link_model (
    input  wire logic       ulpi_clk_out,
    input  wire logic       ulpi_dir,
    input  wire logic       ulpi_nxt,
    output logic            link_stp,
    output logic [7:0]      link_drive
);
    ////////////////////////////////////////////////////////////////////
    // Idle bus held low so a stray zero never reads as a command
    initial begin
        link_stp   = 1'b0;
        link_drive = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////
    // Command byte, wait for NXT, then one STP cycle to close
    // Synchronous mode only; no other bus mode is ever programmed
    task automatic transmit(input logic [7:0] cmd, output bit ok);
        int i;
        @(posedge ulpi_clk_out);
        #1;
        link_drive = cmd;
        ok = 1'b0;
        for (i = 0; i < 40 && !ok; i++) begin
            @(posedge ulpi_clk_out);
            ok = (ulpi_nxt === 1'b1);
        end
        #1;
        link_drive = 8'h00;
        link_stp   = 1'b1;
        @(posedge ulpi_clk_out);
        #1;
        link_stp = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////
    // Abort only while the device owns the bus
    task automatic abort();
        @(posedge ulpi_clk_out);
        #1;
        link_stp = ulpi_dir;
        @(posedge ulpi_clk_out);
        #1;
        link_stp = 1'b0;
    endtask
endmodule // upc_link_model

//--- upc_pkg.sv
// Shared constants and types for the ULPI pin-control block
package upc_pkg;

    // Clock rate and derived figures
    localparam int  SYS_CLK_MHZ      = 250;
    localparam int  ULPI_CLK_MHZ     = 60;
    // Divider for the 60 MHz interface clock: 250/60 is not whole,
    // so a phase accumulator is used with these increments
    localparam logic [7:0] ACC_INC   = 8'h3C;   // 60
    localparam logic [7:0] ACC_MOD   = 8'hFA;   // 250
    localparam logic [7:0] ACC_RESET = 8'h00;

    // Reference clock selections accepted on the oscillator input
    localparam int  REF_KHZ_LOW      = 19200;
    localparam int  REF_KHZ_HIGH     = 26000;

    // Power-up hold in interface ticks before DIR drops
    localparam logic [7:0] PWRUP_TICKS = 8'h10;

    // Reset value of data outputs, and the VBUS good state code
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [1:0] VBUS_OK    = 2'b11;

    // Bus phase encoding
    typedef enum logic [2:0] {
        UPC_POWERUP  = 3'b000,
        UPC_LISTEN   = 3'b001,
        UPC_TURN_OUT = 3'b010,
        UPC_SEND     = 3'b011,
        UPC_TURN_IN  = 3'b100,
        UPC_BLOCK    = 3'b101
    } upc_phase_e;

endpackage

//--- upc_tick_if.sv
// Interface carrying the interface-clock tick between modules
`timescale 1ns/1ps
interface upc_tick_if;
    logic tick;     // One sys_clk pulse per interface clock rising edge
    logic clk_out;  // Generated interface clock level
    modport src (output tick, output clk_out);
    modport dst (input tick, input clk_out);
endinterface // upc_tick_if

//--- upc_top.sv
// ULPI pin control: DIR, NXT, STP, power-down and VBUS switch logic
`timescale 1ns/1ps
module upc_top
    import upc_pkg::*;
#(
    parameter int REF_CLK_KHZ = REF_KHZ_LOW
)
(
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       chip_select_powerdown_n,
    input  wire logic       io_supply_present,
    input  wire logic       suspend_req,
    input  wire logic       ext_fault_input_enable,
    input  wire logic       fault_polarity_invert,
    input  wire logic       external_supply_drive,
    input  wire logic       fault_pin,
    input  wire logic       vbus_valid,
    input  wire logic       link_stp,
    input  wire logic [7:0] link_data_in,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_byte,
    input  wire logic       rx_is_usb,
    output logic            rx_ready,
    input  wire logic       tx_ready,
    output logic            tx_valid,
    output logic [7:0]      tx_byte,
    output logic            tx_last,
    output logic            ulpi_clk_out,
    output logic            ulpi_clk_oe,
    output logic            ulpi_dir,
    output logic            ulpi_dir_oe,
    output logic            ulpi_nxt,
    output logic            ulpi_nxt_oe,
    output logic [7:0]      ulpi_data_out,
    output logic            ulpi_data_oe,
    output logic            vbus_switch_enable_n_out,
    output logic            vbus_switch_enable_n_oe,
    output logic            powered_down,
    output logic [1:0]      vbus_state
);

    // Only two reference rates are served; others refused at elaboration
    if (!(REF_CLK_KHZ inside {REF_KHZ_LOW, REF_KHZ_HIGH})) begin : g_ref
        $error("unsupported reference clock");
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: two flops, first flop read only by the second
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic [7:0] dat1;
    logic [7:0] dat2;

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1 <= '0;
            sync2 <= '0;
            dat1  <= DATA_RESET;
            dat2  <= DATA_RESET;
        end else begin
            sync1 <= {chip_select_powerdown_n, io_supply_present, suspend_req,
                      fault_pin, vbus_valid, link_stp};
            sync2 <= sync1;
            dat1  <= link_data_in;
            dat2  <= dat1;
        end
    end

    logic cs_high;
    logic io_ok;
    logic susp;
    logic fault_s;
    logic vbus_ok_s;
    logic stp_s;
    assign {cs_high, io_ok, susp, fault_s, vbus_ok_s, stp_s} = sync2;

    // Power-down from chip select or missing I/O supply
    logic pwr_down;
    assign pwr_down = cs_high || !io_ok;

    ////////////////////////////////////////////////////////////////////////
    // Interface clock generation
    upc_tick_if tk ();

    upc_clk_gen u_clk_gen (
        .sys_clk (sys_clk),
        .rst_b   (rst_b),
        .run     (!pwr_down),
        .tk      (tk)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus phase state machine, advanced on interface clock rising edges
    upc_phase_e phase;
    upc_phase_e next_phase;
    logic [7:0] pwr_cnt;
    logic [7:0] next_pwr_cnt;
    logic       dir;
    logic       next_dir;
    logic       nxt;
    logic       next_nxt;
    logic [7:0] dout;
    logic [7:0] next_dout;
    logic       txv;
    logic       next_txv;
    logic [7:0] txb;
    logic [7:0] next_txb;
    logic       txl;
    logic       next_txl;
    logic       in_xfer;
    logic       next_in_xfer;

    always_comb begin
        next_phase   = phase;
        next_pwr_cnt = pwr_cnt;
        next_dir     = dir;
        next_nxt     = nxt;
        next_dout    = dout;
        next_txv     = 1'b0;
        next_txb     = txb;
        next_txl     = 1'b0;
        next_in_xfer = in_xfer;
        rx_ready     = 1'b0;
        if (pwr_down) begin
            next_phase   = UPC_POWERUP;
            next_pwr_cnt = '0;
            next_dir     = 1'b1;
            next_nxt     = 1'b0;
            next_in_xfer = 1'b0;
        end else if (tk.tick) begin
            case (phase)
                UPC_POWERUP: begin
                    next_dir = 1'b1;
                    if (pwr_cnt == PWRUP_TICKS) begin
                        next_phase = UPC_TURN_IN;
                        next_dir   = 1'b0;
                    end else begin
                        next_pwr_cnt = 8'(pwr_cnt + 8'h01);
                    end
                end
                UPC_LISTEN: begin
                    next_nxt = 1'b0;
                    if (susp) begin
                        next_phase = UPC_BLOCK;
                        next_dir   = 1'b1;
                    end else if (rx_valid && !in_xfer) begin
                        next_phase = UPC_TURN_OUT;
                        next_dir   = 1'b1;
                    end else if (in_xfer && stp_s) begin
                        // STP cycle carries no byte, only the end mark
                        next_in_xfer = 1'b0;
                        next_txl     = 1'b1;
                    end else if (dat2 != DATA_RESET || in_xfer) begin
                        // Link sees NXT one edge late, so a byte counts
                        // only if it stood while NXT was high
                        next_in_xfer = 1'b1;
                        next_nxt     = tx_ready;
                        next_txv     = in_xfer && nxt;
                        next_txb     = dat2;
                    end
                end
                UPC_TURN_OUT: begin
                    next_phase = UPC_SEND;
                    next_dout  = DATA_RESET;
                end
                UPC_SEND: begin
                    if (stp_s || !rx_valid) begin
                        next_phase = UPC_TURN_IN;
                        next_dir   = 1'b0;
                        next_nxt   = 1'b0;
                    end else begin
                        rx_ready  = 1'b1;
                        next_dout = rx_byte;
                        next_nxt  = rx_is_usb;
                    end
                end
                UPC_TURN_IN: begin
                    next_phase = UPC_LISTEN;
                    next_nxt   = 1'b0;
                end
                UPC_BLOCK: begin
                    next_dir = 1'b1;
                    if (!susp) begin
                        next_phase = UPC_TURN_IN;
                        next_dir   = 1'b0;
                    end
                end
                default: begin
                    next_phase = UPC_POWERUP;
                    next_dir   = 1'b1;
                end
            endcase
        end
    end

    // Outputs registered except rx_ready; DIR starts high so the link cannot drive
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase   <= UPC_POWERUP;
            pwr_cnt <= '0;
            dir     <= 1'b1;
            nxt     <= 1'b0;
            dout    <= DATA_RESET;
            txv     <= 1'b0;
            txb     <= DATA_RESET;
            txl     <= 1'b0;
            in_xfer <= 1'b0;
        end else begin
            phase   <= next_phase;
            pwr_cnt <= next_pwr_cnt;
            dir     <= next_dir;
            nxt     <= next_nxt;
            dout    <= next_dout;
            txv     <= next_txv;
            txb     <= next_txb;
            txl     <= next_txl;
            in_xfer <= next_in_xfer;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // VBUS state and switch; fault polarity applied only when enabled
    logic       fault_act;
    logic [1:0] vstate;
    logic [1:0] next_vstate;
    logic       psw;
    logic       next_psw;
    assign fault_act = ext_fault_input_enable
                       && (fault_s ^ fault_polarity_invert);

    always_comb begin
        next_vstate = (vbus_ok_s && !fault_act) ? VBUS_OK : 2'b00;
        next_psw    = external_supply_drive && !pwr_down;
    end

    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            vstate <= 2'b00;
            psw    <= 1'b0;
        end else begin
            vstate <= next_vstate;
            psw    <= next_psw;
        end
    end

    // Outputs: ULPI pins float while chip select is high
    assign ulpi_clk_out             = tk.clk_out;
    assign ulpi_clk_oe              = !pwr_down;
    assign ulpi_dir                 = dir;
    assign ulpi_dir_oe              = !pwr_down;
    assign ulpi_nxt                 = nxt;
    assign ulpi_nxt_oe              = !pwr_down;
    assign ulpi_data_out            = dout;
    assign ulpi_data_oe             = !pwr_down && dir && phase == UPC_SEND;
    assign vbus_switch_enable_n_out = 1'b0;             // open drain
    assign vbus_switch_enable_n_oe  = psw;
    assign powered_down             = pwr_down;
    assign vbus_state               = vstate;
    assign tx_valid                 = txv;
    assign tx_byte                  = txb;
    assign tx_last                  = txl;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_stp_abort;
        tk.tick && phase == UPC_SEND && stp_s && !pwr_down;
    endsequence

    chk_stp_drops_dir: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_stp_abort |=> !dir)
        else $error("DIR not dropped after stop");

    chk_pwrdown_float: assert property (@(posedge sys_clk) disable iff (!rst_b)
        pwr_down |-> !ulpi_dir_oe && !ulpi_data_oe && !ulpi_clk_oe)
        else $error("pins driven in power-down");

    chk_io_supply: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !io_ok |-> powered_down ##1 (dir && phase == UPC_POWERUP))
        else $error("no power-down without I/O supply");

    chk_switch_drive: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (external_supply_drive && !pwr_down) |=> vbus_switch_enable_n_oe)
        else $error("switch not enabled");

    chk_dir_block: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (phase == UPC_POWERUP || phase == UPC_BLOCK) |-> dir)
        else $error("DIR low while blocking");

    chk_turn_around: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (phase == UPC_TURN_OUT) |-> !ulpi_data_oe)
        else $error("data driven in turnaround");

    chk_nxt_listen: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!dir && !in_xfer) |-> !nxt)
        else $error("NXT high while idle");

    chk_fault_gate: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (!ext_fault_input_enable && vbus_ok_s)[*2] |-> vstate == VBUS_OK)
        else $error("fault reported while disabled");

    chk_dir_in_cause: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(dir) |-> $past(pwr_down) || $past(susp) || $past(rx_valid))
        else $error("DIR raised without cause");

endmodule // upc_top
